// file: core/tcoc_map.svh
// Register offsets, field positions and reset values of the timer/counter block.
`ifndef TCOC_MAP_SVH
`define TCOC_MAP_SVH

`define TCOC_ADDR_W 5
`define TCOC_OFF_CTRL_A 5'h00
`define TCOC_OFF_CTRL_B 5'h04
`define TCOC_OFF_COUNT 5'h08
`define TCOC_OFF_CMP_A 5'h0c
`define TCOC_OFF_CMP_B 5'h10
`define TCOC_OFF_MASK 5'h14
`define TCOC_OFF_FLAG 5'h18

`define TCOC_CA_COM_A_HI 7
`define TCOC_CA_COM_A_LO 6
`define TCOC_CA_COM_B_HI 5
`define TCOC_CA_COM_B_LO 4
`define TCOC_CA_WGM_HI 1
`define TCOC_CA_WGM_LO 0
`define TCOC_CB_FORCE_A 7
`define TCOC_CB_FORCE_B 6
`define TCOC_CB_WGM2 3
`define TCOC_CB_CS_HI 2
`define TCOC_CB_CS_LO 0

`define TCOC_IRQ_OVF 0
`define TCOC_IRQ_CMP_A 1
`define TCOC_IRQ_CMP_B 2

`define TCOC_BOTTOM 8'h00
`define TCOC_MAX 8'hff
`define TCOC_RESET_BYTE 8'h00
`define TCOC_PSC_W 10

`endif

// file: core/tcoc_pkg.sv
// Types shared by the timer/counter block.
package tcoc_pkg;
    typedef enum logic [2:0] {
        TCOC_WGM_NORMAL = 3'h0,
        TCOC_WGM_PC_MAX = 3'h1,
        TCOC_WGM_CTC = 3'h2,
        TCOC_WGM_FAST_MAX = 3'h3,
        TCOC_WGM_RSV4 = 3'h4,
        TCOC_WGM_PC_CMPA = 3'h5,
        TCOC_WGM_RSV6 = 3'h6,
        TCOC_WGM_FAST_CMPA = 3'h7
    } tcoc_wgm_t;

    typedef enum logic [2:0] {
        TCOC_CS_STOP = 3'h0,
        TCOC_CS_DIV1 = 3'h1,
        TCOC_CS_DIV8 = 3'h2,
        TCOC_CS_DIV64 = 3'h3,
        TCOC_CS_DIV256 = 3'h4,
        TCOC_CS_DIV1024 = 3'h5,
        TCOC_CS_EXT_FALL = 3'h6,
        TCOC_CS_EXT_RISE = 3'h7
    } tcoc_cs_t;

    typedef enum logic [1:0] {
        TCOC_COM_NONE = 2'h0,
        TCOC_COM_TOGGLE = 2'h1,
        TCOC_COM_CLEAR = 2'h2,
        TCOC_COM_SET = 2'h3
    } tcoc_com_t;
endpackage

// file: core/tcoc_wavegen.sv
// Waveform generator for one compare output unit.
`timescale 1ns/10ps
module tcoc_wavegen
    import tcoc_pkg::*;
#(
    parameter bit UNIT_A = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic match_event,
    input wire logic force_strobe,
    input wire logic top_event,
    input wire logic count_down,
    input wire tcoc_wgm_t mode,
    input wire tcoc_com_t compare_output_mode,
    output logic compare_out
);
    logic is_fast;
    logic is_phase;
    logic next_out;

    // Non-PWM action for a match or a forced match.
    function automatic logic apply_com(input tcoc_com_t com, input logic cur);
        unique case (com)
            TCOC_COM_NONE: apply_com = cur;
            TCOC_COM_TOGGLE: apply_com = ~cur;
            TCOC_COM_CLEAR: apply_com = 1'b0;
            TCOC_COM_SET: apply_com = 1'b1;
        endcase
    endfunction

    assign is_fast = (mode == TCOC_WGM_FAST_MAX) || (mode == TCOC_WGM_FAST_CMPA);
    assign is_phase = (mode == TCOC_WGM_PC_MAX) || (mode == TCOC_WGM_PC_CMPA);

    always_comb begin
        next_out = compare_out;
        if (is_fast) begin
            // A match takes priority over the bottom restore when compare equals top.
            if (top_event && compare_output_mode[1]) begin
                next_out = ~compare_output_mode[0];
            end
            if (match_event) begin
                if (compare_output_mode[1]) begin
                    next_out = compare_output_mode[0];
                end else if (compare_output_mode[0] && UNIT_A && mode == TCOC_WGM_FAST_CMPA) begin
                    next_out = ~compare_out;
                end
            end
        end else if (is_phase) begin
            if (match_event && compare_output_mode[1]) begin
                next_out = compare_output_mode[0] ^ count_down;
            end else if (match_event && compare_output_mode[0] && UNIT_A && mode == TCOC_WGM_PC_CMPA) begin
                next_out = ~compare_out;
            end
        end else if (match_event || force_strobe) begin
            next_out = apply_com(compare_output_mode, compare_out);
        end
    end

    // The state is never reset by a mode change, only by system reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out <= 1'b0;
        end else begin
            compare_out <= next_out;
        end
    end

    a_force_sets_out: assert property (@(posedge pclk) disable iff (!presetn)
        force_strobe && !is_fast && !is_phase && compare_output_mode == TCOC_COM_SET |=> compare_out)
        else $error("forced set did not raise the compare output");
    a_com_zero_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !is_fast && compare_output_mode == TCOC_COM_NONE |=> $stable(compare_out))
        else $error("compare output moved with output mode zero");
endmodule // tcoc_wavegen

// file: core/tcoc_top.sv
// Eight-bit timer/counter with two output compare units and an APB register slave.
// Overview of operation
// - Count value and both compare values are eight-bit registers; counting is eight-bit.
// - Overflow, compare A, compare B flags sit in the flag register, each maskable.
// - Clock select picks prescaled clock or external pin; zero stops the counter.
// - Software reads and writes the count value at any time.
// - A software count write beats any clear or count in that cycle.
// - Bottom is 0x00, max is 0xff, top is 0xff or compare A by mode.
// - Each tick clears, increments or decrements per the three waveform mode bits.
// - Overflow flag sets where the mode defines it and can request an interrupt.
// - A match sets its compare flag on the next tick; requests interrupt if enabled.
// - Compare flags clear on interrupt service or when software writes one.
// - PWM modes double buffer compare values, updated at top; other modes do not.
// - Buffered modes access the buffer; unbuffered modes access the active value.
// - Force strobe in non-PWM modes acts like a match without flag or clear.
// - A count write blocks every compare match in the following tick.
// - Waveform output follows match, mode and output mode, with top/bottom events.
// - Compare output state is kept across waveform mode changes.
// - Output mode bits take effect at once, without buffering.
// - Mode 0 counts up, wraps from 0xff to 0x00, sets overflow at zero.
// - Mode 2 clears the counter on compare A match; compare A is top.
// - Fast PWM is mode 3 with top 0xff or mode 7 with top compare A.
// - Output mode zero means no action on the output at a match.
`timescale 1ns/10ps
`include "tcoc_map.svh"
module tcoc_top
    import tcoc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_input,
    input wire logic irq_ack_overflow,
    input wire logic irq_ack_compare_a,
    input wire logic irq_ack_compare_b,
    output logic irq_overflow,
    output logic irq_compare_a,
    output logic irq_compare_b,
    output logic compare_out_a,
    output logic compare_out_b,
    output logic compare_out_a_en,
    output logic compare_out_b_en
);
    logic [7:0] control_reg_a;
    logic [3:0] control_reg_b;
    logic [7:0] count_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] compare_a_buf;
    logic [7:0] compare_b_buf;
    logic [2:0] timer_mask_reg;
    logic [2:0] timer_flag_reg;
    logic [`TCOC_PSC_W-1:0] prescaler;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic count_down;
    logic match_block;
    logic force_a;
    logic force_b;
    logic wave_a;
    logic wave_b;

    tcoc_wgm_t waveform_mode_sel;
    tcoc_cs_t clock_select;
    logic [`TCOC_ADDR_W-1:0] reg_addr;
    logic addr_hit;
    logic bus_wr;
    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_count;
    logic wr_cmp_a;
    logic wr_cmp_b;
    logic wr_mask;
    logic wr_flag;
    logic timer_tick;
    logic is_pwm;
    logic is_fast;
    logic is_phase;
    logic [7:0] top_value;
    logic at_top;
    logic top_event;
    logic match_a;
    logic match_b;
    logic match_event_a;
    logic match_event_b;
    logic overflow_event;
    logic [7:0] next_count;
    logic next_down;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [31:0] read_mux;

    // A register is word aligned; any address outside the map answers with an error.
    function automatic logic offset_is(input logic [31:0] addr, input logic [`TCOC_ADDR_W-1:0] off);
        offset_is = (addr[31:`TCOC_ADDR_W] == '0) && (addr[`TCOC_ADDR_W-1:0] == off);
    endfunction

    assign reg_addr = paddr[`TCOC_ADDR_W-1:0];
    assign addr_hit = offset_is(paddr, `TCOC_OFF_CTRL_A) || offset_is(paddr, `TCOC_OFF_CTRL_B) ||
                      offset_is(paddr, `TCOC_OFF_COUNT) || offset_is(paddr, `TCOC_OFF_CMP_A) ||
                      offset_is(paddr, `TCOC_OFF_CMP_B) || offset_is(paddr, `TCOC_OFF_MASK) ||
                      offset_is(paddr, `TCOC_OFF_FLAG);
    assign bus_wr = psel && penable && pready && pwrite && addr_hit;
    assign wr_ctrl_a = bus_wr && reg_addr == `TCOC_OFF_CTRL_A;
    assign wr_ctrl_b = bus_wr && reg_addr == `TCOC_OFF_CTRL_B;
    assign wr_count = bus_wr && reg_addr == `TCOC_OFF_COUNT;
    assign wr_cmp_a = bus_wr && reg_addr == `TCOC_OFF_CMP_A;
    assign wr_cmp_b = bus_wr && reg_addr == `TCOC_OFF_CMP_B;
    assign wr_mask = bus_wr && reg_addr == `TCOC_OFF_MASK;
    assign wr_flag = bus_wr && reg_addr == `TCOC_OFF_FLAG;

    assign waveform_mode_sel = tcoc_wgm_t'({control_reg_b[3], control_reg_a[`TCOC_CA_WGM_HI:`TCOC_CA_WGM_LO]});
    assign clock_select = tcoc_cs_t'(control_reg_b[2:0]);
    assign is_fast = waveform_mode_sel == TCOC_WGM_FAST_MAX || waveform_mode_sel == TCOC_WGM_FAST_CMPA;
    assign is_phase = waveform_mode_sel == TCOC_WGM_PC_MAX || waveform_mode_sel == TCOC_WGM_PC_CMPA;
    assign is_pwm = is_fast || is_phase;

    // Prescaler taps and the synchronised external pin give the tick.
    always_comb begin
        unique case (clock_select)
            TCOC_CS_STOP: timer_tick = 1'b0;
            TCOC_CS_DIV1: timer_tick = 1'b1;
            TCOC_CS_DIV8: timer_tick = &prescaler[2:0];
            TCOC_CS_DIV64: timer_tick = &prescaler[5:0];
            TCOC_CS_DIV256: timer_tick = &prescaler[7:0];
            TCOC_CS_DIV1024: timer_tick = &prescaler[9:0];
            TCOC_CS_EXT_FALL: timer_tick = !ext_s2 && ext_s3;
            TCOC_CS_EXT_RISE: timer_tick = ext_s2 && !ext_s3;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler <= '0;
        end else begin
            prescaler <= prescaler + 1'b1;
        end
    end

    // The pin is asynchronous; only the second and third stages feed the edge detect.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= external_count_input;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    assign top_value = (waveform_mode_sel == TCOC_WGM_CTC || waveform_mode_sel == TCOC_WGM_PC_CMPA ||
                        waveform_mode_sel == TCOC_WGM_FAST_CMPA) ? compare_a_value : `TCOC_MAX;
    assign at_top = count_value == top_value;
    assign top_event = timer_tick && at_top && !count_down;
    assign match_a = count_value == compare_a_value;
    assign match_b = count_value == compare_b_value;
    assign match_event_a = timer_tick && match_a && !match_block;
    assign match_event_b = timer_tick && match_b && !match_block;

    always_comb begin
        next_count = count_value;
        next_down = count_down;
        overflow_event = 1'b0;
        if (timer_tick) begin
            if (is_phase) begin
                if (!count_down && at_top) begin
                    next_down = 1'b1;
                    next_count = count_value - 1'b1;
                end else if (count_down && count_value == `TCOC_BOTTOM) begin
                    next_down = 1'b0;
                    next_count = count_value + 1'b1;
                    overflow_event = 1'b1;
                end else begin
                    next_count = count_down ? count_value - 1'b1 : count_value + 1'b1;
                end
            end else if (at_top) begin
                next_down = 1'b0;
                next_count = `TCOC_BOTTOM;
                overflow_event = is_fast || count_value == `TCOC_MAX;
            end else begin
                next_down = 1'b0;
                next_count = count_value + 1'b1;
                overflow_event = count_value == `TCOC_MAX;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= `TCOC_RESET_BYTE;
            count_down <= 1'b0;
        end else begin
            count_down <= next_down;
            if (wr_count) begin
                count_value <= pwdata[7:0];
            end else begin
                count_value <= next_count;
            end
        end
    end

    // The block holds until the next tick, so it also spans a stopped timer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_block <= 1'b0;
        end else if (wr_count) begin
            match_block <= 1'b1;
        end else if (timer_tick) begin
            match_block <= 1'b0;
        end
    end

    // Buffered compare values move to the active copy at top in PWM modes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_buf <= `TCOC_RESET_BYTE;
            compare_b_buf <= `TCOC_RESET_BYTE;
            compare_a_value <= `TCOC_RESET_BYTE;
            compare_b_value <= `TCOC_RESET_BYTE;
        end else begin
            if (wr_cmp_a) begin
                compare_a_buf <= pwdata[7:0];
            end
            if (wr_cmp_b) begin
                compare_b_buf <= pwdata[7:0];
            end
            if (is_pwm && timer_tick && at_top) begin
                compare_a_value <= compare_a_buf;
                compare_b_value <= compare_b_buf;
            end else if (!is_pwm) begin
                if (wr_cmp_a) begin
                    compare_a_value <= pwdata[7:0];
                end
                if (wr_cmp_b) begin
                    compare_b_value <= pwdata[7:0];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg_a <= `TCOC_RESET_BYTE;
            control_reg_b <= 4'h0;
            timer_mask_reg <= 3'h0;
        end else begin
            if (wr_ctrl_a) begin
                control_reg_a <= pwdata[7:0] & 8'hf3;
            end
            if (wr_ctrl_b) begin
                control_reg_b <= {pwdata[`TCOC_CB_WGM2], pwdata[`TCOC_CB_CS_HI:`TCOC_CB_CS_LO]};
            end
            if (wr_mask) begin
                timer_mask_reg <= pwdata[2:0];
            end
        end
    end

    assign force_a = wr_ctrl_b && pwdata[`TCOC_CB_FORCE_A] && !is_pwm;
    assign force_b = wr_ctrl_b && pwdata[`TCOC_CB_FORCE_B] && !is_pwm;

    // A new event in the clearing cycle wins over the clear.
    assign flag_set = {match_event_b, match_event_a, overflow_event};
    assign flag_clr = (wr_flag ? pwdata[2:0] : 3'h0) |
                      {irq_ack_compare_b, irq_ack_compare_a, irq_ack_overflow};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_flag_reg <= 3'h0;
            irq_overflow <= 1'b0;
            irq_compare_a <= 1'b0;
            irq_compare_b <= 1'b0;
        end else begin
            timer_flag_reg <= flag_set | (timer_flag_reg & ~flag_clr);
            irq_overflow <= timer_flag_reg[`TCOC_IRQ_OVF] && timer_mask_reg[`TCOC_IRQ_OVF];
            irq_compare_a <= timer_flag_reg[`TCOC_IRQ_CMP_A] && timer_mask_reg[`TCOC_IRQ_CMP_A];
            irq_compare_b <= timer_flag_reg[`TCOC_IRQ_CMP_B] && timer_mask_reg[`TCOC_IRQ_CMP_B];
        end
    end

    tcoc_wavegen #(.UNIT_A(1'b1)) u_wave_a (
        .pclk(pclk),
        .presetn(presetn),
        .match_event(match_event_a),
        .force_strobe(force_a),
        .top_event(top_event),
        .count_down(count_down),
        .mode(waveform_mode_sel),
        .compare_output_mode(tcoc_com_t'(control_reg_a[`TCOC_CA_COM_A_HI:`TCOC_CA_COM_A_LO])),
        .compare_out(wave_a)
    );

    tcoc_wavegen #(.UNIT_A(1'b0)) u_wave_b (
        .pclk(pclk),
        .presetn(presetn),
        .match_event(match_event_b),
        .force_strobe(force_b),
        .top_event(top_event),
        .count_down(count_down),
        .mode(waveform_mode_sel),
        .compare_output_mode(tcoc_com_t'(control_reg_a[`TCOC_CA_COM_B_HI:`TCOC_CA_COM_B_LO])),
        .compare_out(wave_b)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_out_a <= 1'b0;
            compare_out_b <= 1'b0;
            compare_out_a_en <= 1'b0;
            compare_out_b_en <= 1'b0;
        end else begin
            compare_out_a <= wave_a;
            compare_out_b <= wave_b;
            compare_out_a_en <= |control_reg_a[`TCOC_CA_COM_A_HI:`TCOC_CA_COM_A_LO];
            compare_out_b_en <= |control_reg_a[`TCOC_CA_COM_B_HI:`TCOC_CA_COM_B_LO];
        end
    end

    always_comb begin
        read_mux = 32'h0000_0000;
        unique case (reg_addr)
            `TCOC_OFF_CTRL_A: read_mux[7:0] = control_reg_a;
            `TCOC_OFF_CTRL_B: read_mux[3:0] = control_reg_b;
            `TCOC_OFF_COUNT: read_mux[7:0] = count_value;
            `TCOC_OFF_CMP_A: read_mux[7:0] = is_pwm ? compare_a_buf : compare_a_value;
            `TCOC_OFF_CMP_B: read_mux[7:0] = is_pwm ? compare_b_buf : compare_b_value;
            `TCOC_OFF_MASK: read_mux[2:0] = timer_mask_reg;
            `TCOC_OFF_FLAG: read_mux[2:0] = timer_flag_reg;
            default: read_mux = 32'h0000_0000;
        endcase
    end

    // One wait-free access phase: pready rises in the first access cycle from a flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready <= 1'b1;
            pslverr <= !addr_hit;
            prdata <= (addr_hit && !pwrite) ? read_mux : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_count_write;
        wr_count;
    endsequence
    sequence s_blocked_tick;
        match_block && timer_tick && !timer_flag_reg[1];
    endsequence
    sequence s_wrap_tick;
        timer_tick && waveform_mode_sel == TCOC_WGM_NORMAL && count_value == `TCOC_MAX && !wr_count;
    endsequence

    a_cpu_write_wins: assert property (s_count_write |=> count_value == $past(pwdata[7:0]) && match_block)
        else $error("count write was overridden");
    a_stop_holds_count: assert property (clock_select == TCOC_CS_STOP && !wr_count
        |=> $stable(count_value))
        else $error("stopped counter moved");
    a_normal_wrap_ovf: assert property (s_wrap_tick |=> count_value == `TCOC_BOTTOM && timer_flag_reg[0])
        else $error("normal mode wrap or overflow flag wrong");
    a_ctc_clear_top: assert property (timer_tick && waveform_mode_sel == TCOC_WGM_CTC && match_a && !wr_count
        |=> count_value == `TCOC_BOTTOM)
        else $error("clear on match did not clear the counter");
    a_match_sets_flag: assert property (timer_tick && match_a && !match_block |=> timer_flag_reg[1])
        else $error("compare A match did not set its flag");
    a_write_blocks_match: assert property (s_blocked_tick |=> !timer_flag_reg[1])
        else $error("match after count write was not blocked");
    a_pwm_buffer_hold: assert property (is_pwm && !(timer_tick && at_top) && $stable(control_reg_a)
        && $stable(control_reg_b) |=> $stable(compare_a_value))
        else $error("active compare changed away from top");
    a_mask_gates_irq: assert property (!timer_mask_reg[0] ##1 !timer_mask_reg[0] |-> !irq_overflow)
        else $error("masked overflow raised an interrupt");
endmodule // tcoc_top

// file: bench/test_timer_counter_output_compare.sv
// Self-checking APB testbench for the timer/counter block.
`timescale 1ns/10ps
`include "tcoc_map.svh"
module test_timer_counter_output_compare
    import tcoc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, external_count_input = 1'b0;
    logic irq_ack_overflow = 1'b0, irq_ack_compare_a = 1'b0, irq_ack_compare_b = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, rerr, irq_overflow, irq_compare_a, irq_compare_b;
    logic compare_out_a, compare_out_b, compare_out_a_en, compare_out_b_en;
    int num_errors = 0, n_tests = 0, cycles = 0;
    localparam logic [4:0] CNT = `TCOC_OFF_COUNT, FLG = `TCOC_OFF_FLAG, CB = `TCOC_OFF_CTRL_B;
    tcoc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .external_count_input, .irq_ack_overflow, .irq_ack_compare_a, .irq_ack_compare_b,
        .irq_overflow, .irq_compare_a, .irq_compare_b, .compare_out_a, .compare_out_b,
        .compare_out_a_en, .compare_out_b_en);
    initial forever #5 pclk = ~pclk;
    task automatic summarize();
        $display("errors %0d in %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // The hang guard sits well above the under two thousand cycles the sequence needs.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {27'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic ack(input logic [2:0] m);
        {irq_ack_compare_b, irq_ack_compare_a, irq_ack_overflow} <= m;
        @(posedge pclk);
        {irq_ack_compare_b, irq_ack_compare_a, irq_ack_overflow} <= 3'h0;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 28; a += 4) rd(5'(a), 32'h0);
        xfer(1'b0, 5'h1c, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(CNT, 32'h1a5);
        rd(CNT, 32'ha5);
        wr(`TCOC_OFF_CMP_B, 32'h10);
        wr(`TCOC_OFF_MASK, 32'h7);
        wr(CNT, 32'h10);
        wr(CB, {29'h0, TCOC_CS_DIV1});
        rd(FLG, 32'h0);
        repeat (300) @(posedge pclk);
        chk({29'h0, irq_compare_b, irq_compare_a, irq_overflow}, 32'h7);
        wr(CB, 32'h0);
        rd(FLG, 32'h7);
        wr(`TCOC_OFF_MASK, 32'h1);
        repeat (2) @(posedge pclk);
        chk({29'h0, irq_compare_b, irq_compare_a, irq_overflow}, 32'h1);
        wr(FLG, 32'h2);
        rd(FLG, 32'h5);
        ack(3'h1);
        rd(FLG, 32'h4);
        ack(3'h4);
        rd(FLG, 32'h0);
        // A top of five keeps every sampled count small only if the clear on match works.
        wr(`TCOC_OFF_CMP_A, 32'h5);
        wr(CNT, 32'h0);
        wr(`TCOC_OFF_CTRL_A, 32'h2);
        wr(CB, {29'h0, TCOC_CS_DIV1});
        repeat (8) begin
            xfer(1'b0, CNT, 32'h0);
            chk({31'h0, rdata <= 32'h5}, 32'h1);
        end
        wr(CB, 32'h0);
        chk({31'h0, compare_out_a}, 32'h0);
        wr(`TCOC_OFF_CTRL_A, {24'h0, TCOC_COM_TOGGLE, 6'h0});
        wr(FLG, 32'h7);
        wr(CNT, 32'h33);
        wr(CB, 32'h80);
        repeat (3) @(posedge pclk);
        chk({28'h0, compare_out_b_en, compare_out_b, compare_out_a_en, compare_out_a}, 32'h3);
        rd(FLG, 32'h0);
        rd(CNT, 32'h33);
        wr(`TCOC_OFF_CTRL_A, {24'h0, TCOC_COM_TOGGLE, 6'h2});
        repeat (3) @(posedge pclk);
        chk({31'h0, compare_out_a}, 32'h1);
        wr(CNT, 32'h0);
        wr(CB, {29'h0, TCOC_CS_EXT_RISE});
        repeat (3) begin
            external_count_input <= 1'b1;
            repeat (4) @(posedge pclk);
            external_count_input <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        rd(CNT, 32'h3);
        // Fast PWM with top at max: a new compare A must wait in the buffer until the wrap.
        wr(`TCOC_OFF_CTRL_A, 32'h3);
        wr(`TCOC_OFF_CMP_A, 32'h20);
        rd(`TCOC_OFF_CMP_A, 32'h20);
        wr(CNT, 32'h8);
        wr(FLG, 32'h7);
        wr(CB, {29'h0, TCOC_CS_DIV1});
        repeat (60) @(posedge pclk);
        rd(FLG, 32'h4);
        repeat (300) @(posedge pclk);
        rd(FLG, 32'h7);
        chk({30'h0, compare_out_a_en, compare_out_a}, 32'h1);
        summarize();
    end
endmodule // test_timer_counter_output_compare
